// *** logic/ast_uart.sv ***
// Asynchronous serial transceiver core: baud divider, transmitter, receiver
`timescale 1ns/1ps
`default_nettype none
`include "ast_regs.svh"
module ast_uart
    import ast_pkg::*;
(
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    input  wire logic [15:0] i_mode,
    input  wire logic [15:0] i_baud_div,
    input  wire logic        i_txisel,
    input  wire logic [1:0]  i_rxisel,
    input  wire logic        i_txen_set,
    input  wire logic        i_txen_clr,
    input  wire logic        i_brk_set,
    input  wire logic        i_brk_clr,
    input  wire logic        i_tx_wr,
    input  wire logic [8:0]  i_tx_data,
    input  wire logic        i_rx_rd,
    input  wire logic        i_overrun_flag_clr,
    input  wire logic        i_rx_pin,
    input  wire logic        i_alt_rx_pin,
    output logic             o_tx_pin,
    output logic             o_tx_oe,
    output logic             o_alt_tx_pin,
    output logic             o_alt_tx_oe,
    output logic [15:0]      o_status,
    output logic [8:0]       o_rx_data,
    output logic             o_tx_irq,
    output logic             o_rx_irq
);
    // ----------------------------------------
    // Mode decode
    // ----------------------------------------
    wire       en       = i_mode[`AST_MODE_EN_BIT];
    wire       alt      = i_mode[`AST_MODE_ALT_BIT];
    wire [1:0] fmt_bits = i_mode[`AST_MODE_FMT_HI:`AST_MODE_FMT_LO];
    wire       two_stop = i_mode[`AST_MODE_STOP_BIT];
    wire       nine     = (fmt_bits == AST_FMT_9N);
    wire       has_par  = (fmt_bits == AST_FMT_8E) || (fmt_bits == AST_FMT_8O);
    wire       odd_par  = (fmt_bits == AST_FMT_8O);
    wire [3:0] nbits    = nine ? 4'h9 : 4'h8;

    // Parity over the low eight bits
    function automatic logic par_of(input logic [8:0] d, input logic odd);
        par_of = (^d[7:0]) ^ odd;
    endfunction : par_of

    // ----------------------------------------
    // Baud divider and 16x tick
    // ----------------------------------------
    logic [15:0] baud_cnt;
    logic [3:0]  tx_sub;
    logic        tick16;
    logic        txen;
    wire         baud_restart = !en || (i_txen_set && !txen);

    // Counter cleared on disable so a fresh enable starts clean
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn || baud_restart)
        begin
            baud_cnt <= `AST_BAUD_RESET;
            tick16   <= 1'b0;
        end
        else if (baud_cnt >= i_baud_div)
        begin
            baud_cnt <= `AST_BAUD_RESET;
            tick16   <= 1'b1;
        end
        else
        begin
            baud_cnt <= baud_cnt + 16'h0001;
            tick16   <= 1'b0;
        end
    end

    // Transmit bit tick: one per 16 subticks, first at restart
    wire tx_bit_tick = tick16 && (tx_sub == 4'h0);
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn || baud_restart)
        begin
            tx_sub <= 4'h0;
        end
        else if (tick16)
        begin
            tx_sub <= tx_sub + 4'h1;
        end
    end

    // ----------------------------------------
    // Input synchronisers and pin mux
    // ----------------------------------------
    logic [1:0] rx_sync;
    logic [1:0] arx_sync;
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            rx_sync  <= 2'b11;
            arx_sync <= 2'b11;
        end
        else
        begin
            rx_sync  <= {rx_sync[0], i_rx_pin};
            arx_sync <= {arx_sync[0], i_alt_rx_pin};
        end
    end
    wire rx_line = alt ? arx_sync[1] : rx_sync[1];

    // ----------------------------------------
    // Transmit buffer and shifter
    // ----------------------------------------
    logic [8:0]  txf_head;
    logic [2:0]  txf_count;
    logic        brk;
    ast_state_t  tx_state;
    logic [3:0]  tx_idx;
    logic [8:0]  tx_shift;
    logic        tx_line;
    wire         txf_full = (txf_count == 3'h4);
    wire         tx_load  = en && txen && !brk && (tx_state == AST_S_IDLE)
                            && (txf_count != 3'h0);
    wire         tx_push  = en && i_tx_wr && !txf_full;

    ast_fifo #(.WIDTH(9), .DEPTH(4)) u_txf (
        .i_clk   (i_clk),
        .i_resetn(i_resetn),
        .i_flush (!en),
        .i_push  (tx_push),
        .i_data  (i_tx_data),
        .i_pop   (tx_load),
        .o_head  (txf_head),
        .o_count (txf_count)
    );

    // Transmit state machine, one bit per transmit tick
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn || !en)
        begin
            tx_state <= AST_S_IDLE;
            tx_idx   <= 4'h0;
            tx_shift <= 9'h000;
            tx_line  <= 1'b1;
        end
        else
        begin
            case (tx_state)
                AST_S_IDLE:
                begin
                    tx_line <= 1'b1;
                    if (tx_load)
                    begin
                        tx_shift <= txf_head;
                        tx_state <= AST_S_START;
                    end
                end
                AST_S_START:
                begin
                    if (tx_bit_tick)
                    begin
                        tx_line  <= 1'b0;
                        tx_idx   <= 4'h0;
                        tx_state <= AST_S_DATA;
                    end
                end
                AST_S_DATA:
                begin
                    if (tx_bit_tick)
                    begin
                        tx_line  <= tx_shift[tx_idx];
                        tx_idx   <= tx_idx + 4'h1;
                        if (tx_idx == nbits - 4'h1)
                        begin
                            tx_state <= has_par ? AST_S_PAR : AST_S_STOP;
                            tx_idx   <= 4'h0;
                        end
                    end
                end
                AST_S_PAR:
                begin
                    if (tx_bit_tick)
                    begin
                        tx_line  <= par_of(tx_shift, odd_par);
                        tx_state <= AST_S_STOP;
                    end
                end
                AST_S_STOP:
                begin
                    if (tx_bit_tick)
                    begin
                        tx_line <= 1'b1;
                        tx_idx  <= tx_idx + 4'h1;
                        if (tx_idx == {3'h0, two_stop})
                        begin
                            tx_state <= AST_S_WAIT;
                        end
                    end
                end
                AST_S_WAIT:
                begin
                    if (tx_bit_tick)
                    begin
                        tx_state <= AST_S_IDLE;
                    end
                end
                default:
                begin
                    tx_state <= AST_S_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Receiver
    // ----------------------------------------
    ast_state_t rx_state;
    logic [3:0] rx_sub;
    logic [3:0] rx_idx;
    logic [8:0] rx_shift;
    logic       rx_parity_error_flag;
    logic       rx_framing_error_flag;
    logic       rx_pend;
    logic       overrun_flag;
    logic       rx_line_q;
    logic [10:0] rxf_head;
    logic [2:0]  rxf_count;
    wire        rx_samp = tick16 && (rx_sub == `AST_MID_SAMPLE);
    wire        rxf_full = (rxf_count == 3'h4);
    wire        rx_push  = en && rx_pend && !rxf_full;
    wire        rx_pop   = en && i_rx_rd;
    wire        rx_done  = rx_samp && (rx_state == AST_S_STOP)
                           && (rx_idx == {3'h0, two_stop});
    // Stop bit seen with a full buffer: the word stays in the shifter
    wire        set_overrun_flag = rx_done && rxf_full;

    ast_fifo #(.WIDTH(11), .DEPTH(4)) u_rxf (
        .i_clk   (i_clk),
        .i_resetn(i_resetn),
        .i_flush (!en),
        .i_push  (rx_push),
        .i_data  ({rx_framing_error_flag, rx_parity_error_flag, rx_shift}),
        .i_pop   (rx_pop),
        .o_head  (rxf_head),
        .o_count (rxf_count)
    );

    // Character framing; held off entirely while overrun stands
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn || !en)
        begin
            rx_state  <= AST_S_IDLE;
            rx_sub    <= 4'h0;
            rx_idx    <= 4'h0;
            rx_shift  <= 9'h000;
            rx_parity_error_flag   <= 1'b0;
            rx_framing_error_flag   <= 1'b0;
            rx_pend   <= 1'b0;
            rx_line_q <= 1'b1;
        end
        else
        begin
            rx_line_q <= rx_line;
            if (rx_push)
            begin
                rx_pend <= 1'b0;
            end
            if (tick16)
            begin
                rx_sub <= rx_sub + 4'h1;
            end
            case (rx_state)
                AST_S_IDLE:
                begin
                    if (!overrun_flag && rx_line_q && !rx_line)
                    begin
                        rx_state <= AST_S_START;
                        rx_sub   <= 4'h0;
                    end
                end
                AST_S_START:
                begin
                    if (rx_samp)
                    begin
                        rx_state <= rx_line ? AST_S_IDLE : AST_S_DATA;
                        rx_idx   <= 4'h0;
                        rx_shift <= 9'h000;
                    end
                end
                AST_S_DATA:
                begin
                    if (rx_samp)
                    begin
                        rx_shift[rx_idx] <= rx_line;
                        rx_idx <= rx_idx + 4'h1;
                        if (rx_idx == nbits - 4'h1)
                        begin
                            rx_state <= has_par ? AST_S_PAR : AST_S_STOP;
                            rx_idx   <= 4'h0;
                        end
                    end
                end
                AST_S_PAR:
                begin
                    if (rx_samp)
                    begin
                        rx_parity_error_flag  <= (rx_line != par_of(rx_shift, odd_par));
                        rx_state <= AST_S_STOP;
                    end
                end
                AST_S_STOP:
                begin
                    if (rx_samp)
                    begin
                        if (rx_idx == 4'h0)
                        begin
                            rx_framing_error_flag <= !rx_line;
                        end
                        else if (!rx_line)
                        begin
                            rx_framing_error_flag <= 1'b1;
                        end
                        rx_idx <= rx_idx + 4'h1;
                        // Held word waits in the shifter with rx_pend set until the buffer has room
                        if (rx_done)
                        begin
                            rx_pend  <= 1'b1;
                            rx_state <= AST_S_WAIT;
                        end
                    end
                end
                AST_S_WAIT:
                begin
                    // A long break must end before the next start is sought
                    if (rx_line)
                    begin
                        rx_state <= AST_S_IDLE;
                        if (!rx_pend)
                        begin
                            rx_parity_error_flag <= 1'b0;
                            rx_framing_error_flag <= 1'b0;
                        end
                    end
                end
                default:
                begin
                    rx_state <= AST_S_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Control flags and events
    // ----------------------------------------
    wire [2:0] rx_next_cnt = rxf_count + 3'h1;
    wire rx_evt = rx_push && ((i_rxisel[1] == 1'b0)
                  || (i_rxisel == 2'b10 && rx_next_cnt == `AST_RX_THREE)
                  || (i_rxisel == 2'b11 && rx_next_cnt == 3'h4));
    wire tx_evt = tx_load && (!i_txisel || txf_count == 3'h1);
    wire tx_busy = (tx_state != AST_S_IDLE);

    // Set of overrun beats software clear
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn || !en)
        begin
            txen     <= 1'b0;
            brk      <= 1'b0;
            overrun_flag     <= 1'b0;
            o_tx_irq <= 1'b0;
            o_rx_irq <= 1'b0;
        end
        else
        begin
            txen     <= i_txen_set ? 1'b1 : (i_txen_clr ? 1'b0 : txen);
            brk      <= i_brk_set ? 1'b1 : (i_brk_clr ? 1'b0 : brk);
            overrun_flag     <= set_overrun_flag ? 1'b1 : (i_overrun_flag_clr ? 1'b0 : overrun_flag);
            o_tx_irq <= tx_evt;
            o_rx_irq <= rx_evt;
        end
    end

    // ----------------------------------------
    // Registered pins and status
    // ----------------------------------------
    wire tx_out = brk ? 1'b0 : tx_line;
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn)
        begin
            o_tx_pin     <= 1'b1;
            o_tx_oe      <= 1'b0;
            o_alt_tx_pin <= 1'b1;
            o_alt_tx_oe  <= 1'b0;
            o_status     <= `AST_STA_RESET;
            o_rx_data    <= 9'h000;
        end
        else
        begin
            o_tx_pin     <= alt ? 1'b1 : tx_out;
            o_tx_oe      <= en && !alt;
            o_alt_tx_pin <= alt ? tx_out : 1'b1;
            o_alt_tx_oe  <= en && alt;
            o_rx_data    <= rxf_head[8:0];
            o_status     <= 16'h0000;
            o_status[`AST_STA_TXISEL_BIT] <= i_txisel;
            o_status[`AST_STA_BRK_BIT]    <= brk;
            o_status[`AST_STA_TXEN_BIT]   <= txen;
            o_status[`AST_STA_TXBF_BIT]   <= txf_full;
            o_status[`AST_STA_SHE_BIT]    <= !tx_busy;
            o_status[`AST_STA_RXISEL_HI:`AST_STA_RXISEL_LO] <= i_rxisel;
            o_status[`AST_STA_RECEIVER_IDLE_FLAG_BIT]  <= (rx_state == AST_S_IDLE);
            o_status[`AST_STA_PARITY_ERROR_FLAG_BIT]   <= (rxf_count != 3'h0) && rxf_head[9];
            o_status[`AST_STA_FRAMING_ERROR_FLAG_BIT]   <= (rxf_count != 3'h0) && rxf_head[10];
            o_status[`AST_STA_OVERRUN_FLAG_BIT]   <= overrun_flag;
            o_status[`AST_STA_RXDA_BIT]   <= (rxf_count != 3'h0);
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    sequence s_disable;
        !en;
    endsequence
    AST_DIS_FLAGS: assert property (@(posedge i_clk) disable iff (!i_resetn)
        s_disable ##1 s_disable |=> (o_status[`AST_STA_RXDA_BIT] == 1'b0) && o_status[`AST_STA_SHE_BIT])
        else $error("flags not reset on disable");
    AST_BREAK_LOW: assert property (@(posedge i_clk) disable iff (!i_resetn)
        brk && !alt |=> !o_tx_pin)
        else $error("break did not drive line low");
    AST_IDLE_HIGH: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !brk && !tx_busy && !alt && en |=> o_tx_pin)
        else $error("idle line not high");
    AST_FULL_DROP: assert property (@(posedge i_clk) disable iff (!i_resetn)
        en && i_tx_wr && txf_full && !tx_load |=> txf_count == 3'h4)
        else $error("write to full buffer changed it");
    AST_TX_EVT: assert property (@(posedge i_clk) disable iff (!i_resetn)
        en && tx_load && !i_txisel |=> o_tx_irq)
        else $error("missing transmit event");
    AST_OVERRUN_FLAG_SET: assert property (@(posedge i_clk) disable iff (!i_resetn)
        en && set_overrun_flag |=> overrun_flag ##1 o_status[`AST_STA_OVERRUN_FLAG_BIT])
        else $error("overrun not flagged");
    AST_RXDA: assert property (@(posedge i_clk) disable iff (!i_resetn)
        en && rxf_count != 3'h0 |=> o_status[`AST_STA_RXDA_BIT])
        else $error("data available wrong");
    AST_RX_HOLD: assert property (@(posedge i_clk) disable iff (!i_resetn)
        en && overrun_flag && rx_state == AST_S_IDLE |=> rx_state == AST_S_IDLE)
        else $error("receiver ran during overrun");
    AST_OE_EN: assert property (@(posedge i_clk) disable iff (!i_resetn)
        en ##1 en |=> (o_tx_oe || o_alt_tx_oe))
        else $error("transmit pin not driven while enabled");
endmodule : ast_uart
`default_nettype wire

// *** logic/ast_regs.svh ***
// Constants for the asynchronous serial transceiver
`ifndef AST_REGS_SVH
`define AST_REGS_SVH
// Mode register fields
`define AST_MODE_EN_BIT      15
`define AST_MODE_ALT_BIT     10
`define AST_MODE_FMT_HI      2
`define AST_MODE_FMT_LO      1
`define AST_MODE_STOP_BIT    0
`define AST_MODE_RESET       16'h0000
// Status/control register fields
`define AST_STA_TXISEL_BIT   15
`define AST_STA_BRK_BIT      11
`define AST_STA_TXEN_BIT     10
`define AST_STA_TXBF_BIT     9
`define AST_STA_SHE_BIT      8
`define AST_STA_RXISEL_HI    7
`define AST_STA_RXISEL_LO    6
`define AST_STA_RECEIVER_IDLE_FLAG_BIT    4
`define AST_STA_PARITY_ERROR_FLAG_BIT     3
`define AST_STA_FRAMING_ERROR_FLAG_BIT     2
`define AST_STA_OVERRUN_FLAG_BIT     1
`define AST_STA_RXDA_BIT     0
`define AST_STA_RESET        16'h0110
// Timing
`define AST_OVERSAMPLE       16
`define AST_MID_SAMPLE       4'h7
`define AST_RX_THREE         3
`define AST_BAUD_RESET       16'h0000
`endif

// *** logic/ast_pkg.sv ***
// Types for the asynchronous serial transceiver
package ast_pkg;
    typedef enum logic [1:0]
    {
        AST_FMT_8N = 2'b00,
        AST_FMT_8E = 2'b01,
        AST_FMT_8O = 2'b10,
        AST_FMT_9N = 2'b11
    } ast_fmt_t;
    typedef enum logic [2:0]
    {
        AST_S_IDLE  = 3'b000,
        AST_S_START = 3'b001,
        AST_S_DATA  = 3'b010,
        AST_S_PAR   = 3'b011,
        AST_S_STOP  = 3'b100,
        AST_S_WAIT  = 3'b101
    } ast_state_t;
endpackage : ast_pkg

// *** logic/ast_fifo.sv ***
// Small synchronous FIFO used by both directions
`timescale 1ns/1ps
`default_nettype none
module ast_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 4
) (
    input  wire logic             i_clk,
    input  wire logic             i_resetn,
    input  wire logic             i_flush,
    input  wire logic             i_push,
    input  wire logic [WIDTH-1:0] i_data,
    input  wire logic             i_pop,
    output logic      [WIDTH-1:0] o_head,
    output logic      [2:0]       o_count
);
    // ----------------------------------------
    // Storage, shifted toward the head on pop
    // ----------------------------------------
    logic [WIDTH-1:0] mem [DEPTH];
    logic [2:0]       count;
    wire              do_pop  = i_pop && (count != 3'h0);
    wire              do_push = i_push && ((count != DEPTH[2:0]) || do_pop);
    wire  [2:0]       wr_idx  = do_pop ? count - 3'h1 : count;

    assign o_head  = mem[0];
    assign o_count = count;

    // Empty pop keeps contents and head untouched
    always_ff @(posedge i_clk)
    begin
        if (!i_resetn || i_flush)
        begin
            count <= 3'h0;
        end
        else
        begin
            if (do_pop)
            begin
                for (int i = 0; i < DEPTH - 1; i++)
                begin
                    mem[i] <= mem[i+1];
                end
            end
            if (do_push)
            begin
                mem[wr_idx[1:0]] <= i_data;
            end
            count <= count + {2'h0, do_push} - {2'h0, do_pop};
        end
    end
endmodule : ast_fifo
`default_nettype wire

// *** tb/ast_remote.sv ***
// Remote serial device model facing the transceiver
`timescale 1ns/1ps
`default_nettype none
module ast_remote #(
    parameter int BIT = 32
) (
    input  wire logic i_clk,
    input  wire logic i_line,
    output logic      o_line
);
    logic [7:0] got[$];
    logic [7:0] sh;

    // ----------------------------------------
    // Send: start, 8 data LSB first, one stop
    // ----------------------------------------
    task automatic send(input logic [7:0] d);
        for (int k = 0; k < 10; k++)
        begin
            o_line <= (k == 0) ? 1'b0 : (k == 9) ? 1'b1 : d[k-1];
            repeat (BIT) @(posedge i_clk);
        end
    endtask : send

    // ----------------------------------------
    // Receive: mid-bit sampling, bad stop dropped
    // ----------------------------------------
    initial
    begin
        o_line = 1'b1;
        forever
        begin
            @(negedge i_line);
            repeat (BIT + BIT / 2) @(posedge i_clk);
            for (int k = 0; k < 8; k++)
            begin
                sh[k] = i_line;
                repeat (BIT) @(posedge i_clk);
            end
            if (i_line === 1'b1)
                got.push_back(sh);
        end
    end
endmodule : ast_remote
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the serial transceiver core
`timescale 1ns/1ps
`default_nettype none
`include "ast_regs.svh"
module tb;
    logic        i_clk, i_resetn, i_txisel, i_txen_set, i_txen_clr;
    logic        i_tx_wr, i_rx_rd, rx_line, i_brk_set, i_brk_clr, i_overrun_flag_clr;
    logic [1:0]  i_rxisel;
    logic [15:0] i_mode, i_baud_div, o_status;
    logic [8:0]  i_tx_data, o_rx_data;
    logic        o_tx_pin, o_tx_oe, o_alt_tx_pin, o_alt_tx_oe, o_tx_irq, o_rx_irq;
    logic [7:0]  exp_tx[$], exp_rx[$], b;
    logic [31:0] seed;
    int          error_cnt, num_checks, tx_irqs, rx_irqs, cyc;

    ast_uart i_dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_mode(i_mode), .i_baud_div(i_baud_div),
        .i_txisel(i_txisel), .i_rxisel(i_rxisel), .i_txen_set(i_txen_set), .i_txen_clr(i_txen_clr),
        .i_brk_set(i_brk_set), .i_brk_clr(i_brk_clr), .i_tx_wr(i_tx_wr), .i_tx_data(i_tx_data),
        .i_rx_rd(i_rx_rd), .i_overrun_flag_clr(i_overrun_flag_clr), .i_rx_pin(rx_line), .i_alt_rx_pin(1'b1),
        .o_tx_pin(o_tx_pin), .o_tx_oe(o_tx_oe), .o_alt_tx_pin(o_alt_tx_pin),
        .o_alt_tx_oe(o_alt_tx_oe), .o_status(o_status), .o_rx_data(o_rx_data),
        .o_tx_irq(o_tx_irq), .o_rx_irq(o_rx_irq));
    // Divider 1 gives 32 clocks a bit
    ast_remote #(.BIT(32)) i_rem (.i_clk(i_clk), .i_line(o_tx_pin), .o_line(rx_line));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask : tick
    // Next state of the 32-bit shift register
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    // Next random byte from the shift register
    task automatic rnd();
        seed = lfsr(seed);
        b = seed[7:0];
    endtask : rnd
    task automatic wr(input logic [7:0] d);
        tick(1);
        i_tx_wr   <= 1'b1;
        i_tx_data <= {1'b0, d};
        tick(1);
        i_tx_wr   <= 1'b0;
    endtask : wr
    // Bounded wait for the far side, then compare in order
    task automatic drain(input int n);
        for (int t = 0; t < 4000 && i_rem.got.size() < n; t++)
            tick(1);
        tick(40);
        chk(i_rem.got.size(), exp_tx.size());
        while (exp_tx.size() > 0 && i_rem.got.size() > 0)
            chk(i_rem.got.pop_front(), exp_tx.pop_front());
    endtask : drain
    // Read out every expected word in order
    task automatic rd_all();
        while (exp_rx.size() > 0)
        begin
            chk(o_rx_data, exp_rx.pop_front());
            i_rx_rd <= 1'b1;
            tick(1);
            i_rx_rd <= 1'b0;
            tick(3);
        end
    endtask : rd_all
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test

    initial
    begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    // Event counters and hang guard
    always @(posedge i_clk)
    begin
        tx_irqs += (o_tx_irq === 1'b1);
        rx_irqs += (o_rx_irq === 1'b1);
        cyc++;
        if (cyc == 20000)
        begin
            error_cnt++;
            end_of_test();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        {i_resetn, i_txisel, i_txen_set, i_txen_clr, i_tx_wr, i_rx_rd} = '0;
        {i_brk_set, i_brk_clr, i_overrun_flag_clr, i_rxisel} = '0;
        i_mode = 16'h0000;
        i_baud_div = 16'h0001;
        i_tx_data = 9'h000;
        seed = 32'hfedd;
        tick(10);
        i_resetn <= 1'b1;
        tick(2);
        chk(o_status, `AST_STA_RESET);
        chk(o_tx_pin, 1'b1);
        i_mode <= 16'h8000;
        tick(3);
        chk({o_tx_oe, o_alt_tx_oe}, 2'b10);
        // Back-to-back words with transmit enabled
        i_txen_set <= 1'b1;
        tick(1);
        i_txen_set <= 1'b0;
        for (int k = 0; k < 3; k++)
        begin
            rnd();
            exp_tx.push_back(b);
            wr(b);
        end
        drain(3);
        chk(tx_irqs, 3);
        // Queue five with transmit off: fifth is dropped
        i_txen_clr <= 1'b1;
        tick(1);
        i_txen_clr <= 1'b0;
        for (int k = 0; k < 5; k++)
        begin
            rnd();
            if (k < 4)
                exp_tx.push_back(b);
            wr(b);
        end
        tick(3);
        chk(o_status[9], 1'b1);
        chk(i_rem.got.size(), 0);
        // Event only on the emptying transfer, two stop bits
        i_txisel   <= 1'b1;
        i_mode     <= 16'h8001;
        i_txen_set <= 1'b1;
        tick(1);
        i_txen_set <= 1'b0;
        drain(4);
        chk(tx_irqs, 4);
        i_txisel <= 1'b0;
        i_mode   <= 16'h8000;
        // Two received words, read out in order
        for (int k = 0; k < 2; k++)
        begin
            rnd();
            exp_rx.push_back(b);
            i_rem.send(b);
        end
        tick(40);
        chk(o_status[0], 1'b1);
        chk(rx_irqs, 2);
        rd_all();
        chk(o_status[0], 1'b0);
        // Five unread words: event at full, fifth held under overrun
        i_rxisel <= 2'b11;
        for (int k = 0; k < 5; k++)
        begin
            rnd();
            exp_rx.push_back(b);
            i_rem.send(b);
        end
        tick(40);
        chk(o_status[1], 1'b1);
        chk(rx_irqs, 3);
        i_rxisel <= 2'b00;
        rd_all();
        i_overrun_flag_clr <= 1'b1;
        tick(1);
        i_overrun_flag_clr <= 1'b0;
        tick(2);
        chk(o_status[1:0], 2'b00);
        // Break held over 13 bit times, then two idle bit times
        i_brk_set <= 1'b1;
        tick(1);
        i_brk_set <= 1'b0;
        tick(420);
        chk(o_tx_pin, 1'b0);
        i_brk_clr <= 1'b1;
        tick(1);
        i_brk_clr <= 1'b0;
        tick(64);
        chk({o_tx_pin, o_status[11]}, 2'b10);
        chk(tx_irqs, 4);
        chk(i_rem.got.size(), 0);
        // Disable in mid-frame with two words queued behind it
        rnd();
        wr(b);
        i_txen_clr <= 1'b1;
        tick(1);
        i_txen_clr <= 1'b0;
        wr(b);
        wr(b);
        tick(50);
        i_mode <= 16'h0000;
        tick(3);
        chk(o_status, `AST_STA_RESET);
        chk({o_tx_pin, o_tx_oe}, 2'b10);
        // Re-enable on the alternate pair, then one word on the primary
        tick(400);
        i_rem.got.delete();
        i_mode <= 16'h8400;
        tick(3);
        chk({o_tx_oe, o_alt_tx_oe, o_alt_tx_pin}, 3'b011);
        i_mode     <= 16'h8000;
        i_txen_set <= 1'b1;
        tick(1);
        i_txen_set <= 1'b0;
        rnd();
        exp_tx.push_back(b);
        wr(b);
        drain(1);
        end_of_test();
    end
endmodule : tb
`default_nettype wire
